// *** bench/host_port_sva.sv ***
// checker watching the link wires between the two ends
`timescale 1ns/10ps
module host_port_sva
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // link wires
   input wire logic       hostChipSelectN,
   input wire logic       directionSelect,
   input wire logic       controlSelect,
   input wire logic [3:0] byteLaneEnablesN,
   input wire logic       hostDataOe,
   input wire logic       devDataOe,
   input wire logic       portReadyAckN,
   input wire logic       hostBusRequestN,
   input wire logic       hostBusGrantN,
   input wire logic       timerOutputN,
   input wire logic       irqAckCycle,
   input wire logic       autovectorInputN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ***********************************
   // cycles since the last acknowledge
   // ***********************************
   logic [3:0] ackAge_q;
   logic [3:0] ackAge_d;
   always_comb
   begin
      ackAge_d = ackAge_q;
      if (irqAckCycle)
         ackAge_d = 4'h0;
      else if (ackAge_q != 4'hF)
         ackAge_d = ackAge_q + 4'h1;
   end
   // starts saturated so a reset never looks like a fresh acknowledge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ackAge_q <= 4'hF;
      else
         ackAge_q <= ackAge_d;
   end
   // ***********************************
   // properties
   // ***********************************
   AST_READY_WITH_CS: assert property (
      $fell(portReadyAckN) |-> !hostChipSelectN)
      else $error("ready asserted without chip select");
   AST_READY_RELEASE: assert property (
      $rose(hostChipSelectN) |-> ##[1:6] portReadyAckN)
      else $error("ready not released after strobe end");
   AST_CS_UNTIL_READY: assert property (
      !hostChipSelectN && portReadyAckN |=> !hostChipSelectN)
      else $error("strobe dropped before ready");
   AST_CS_RELEASE: assert property (
      $fell(portReadyAckN) |-> ##[1:8] hostChipSelectN)
      else $error("strobe not ended after ready");
   AST_PINS_STABLE: assert property (
      !hostChipSelectN && !$past(hostChipSelectN) |->
         $stable(controlSelect) && $stable(directionSelect)
         && $stable(byteLaneEnablesN))
      else $error("select lines moved during strobe");
   AST_NO_CONTENTION: assert property (
      !(hostDataOe && devDataOe))
      else $error("both ends drive the data bus");
   AST_WRITE_DIR: assert property (
      hostDataOe |-> !directionSelect)
      else $error("host drives data during a read");
   AST_IRQ_ACKED: assert property (
      $fell(timerOutputN) |-> ##[1:10] irqAckCycle)
      else $error("interrupt never acknowledged");
   AST_IRQ_HELD: assert property (
      !timerOutputN && ackAge_q > 4'h6 |=> !timerOutputN)
      else $error("interrupt released without acknowledge");
   AST_GRANT: assert property (
      $fell(hostBusRequestN) |-> ##[1:8] !hostBusGrantN)
      else $error("bus request not granted");
   AST_AUTOVECTOR_INPUT_LOW: assert property (
      !autovectorInputN)
      else $error("autovector input not held low");
endmodule : host_port_sva

// *** bench/tb.sv ***
// top-level bench: both ends of the host port joined through the link
`timescale 1ns/10ps
`include "host_port_consts.svh"
module tb
   import host_port_pkg::*;
;
   // ***********************************
   // signals and instances
   // ***********************************
   logic        clk;
   logic        rst_n;
   logic        clkEn;
   logic        pselH;
   logic        pselD;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdataH;
   logic [31:0] prdataD;
   logic        preadyH;
   logic        preadyD;
   logic        pslverrH;
   logic        pslverrD;
   logic        irqH;
   logic        irqD;
   logic [31:0] rdat;
   logic        rerr;
   int          failures;
   int          checks_done;
   host_port_if lnk();
   host_end host_end_i (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
      .psel(pselH), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdataH), .pready(preadyH),
      .pslverr(pslverrH), .irq(irqH), .link(lnk.host));
   device_end device_end_i (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
      .psel(pselD), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdataD), .pready(preadyD),
      .pslverr(pslverrD), .irq(irqD), .link(lnk.device));
   host_port_sva host_port_sva_i (.clk(clk), .rst_n(rst_n),
      .hostChipSelectN(lnk.hostChipSelectN),
      .directionSelect(lnk.directionSelect),
      .controlSelect(lnk.controlSelect),
      .byteLaneEnablesN(lnk.byteLaneEnablesN),
      .hostDataOe(lnk.hostDataOe), .devDataOe(lnk.devDataOe),
      .portReadyAckN(lnk.portReadyAckN),
      .hostBusRequestN(lnk.hostBusRequestN),
      .hostBusGrantN(lnk.hostBusGrantN), .timerOutputN(lnk.timerOutputN),
      .irqAckCycle(lnk.irqAckCycle),
      .autovectorInputN(lnk.autovectorInputN));
   // ***********************************
   // shared tasks
   // ***********************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one apb cycle; entered just after a rising edge
   task automatic apb(input bit dev, input bit wr, input logic [7:0] a,
                      input logic [31:0] wd);
      pselH  <= !dev;
      pselD  <= dev;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // ends when the selected end raises pready; the watchdog ends a hung wait
      do
      begin
         @(posedge clk);
      end
      while (!(dev ? preadyD : preadyH));
      rdat = dev ? prdataD : prdataH;
      rerr = dev ? pslverrD : pslverrH;
      pselH   <= 1'b0;
      pselD   <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input bit dev, input logic [7:0] a, input logic [31:0] d);
      apb(dev, 1'b1, a, d);
   endtask : wr
   task automatic rd(input bit dev, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] exp);
      apb(dev, 1'b0, a, 32'h0000_0000);
      check(rdat & m, exp);
   endtask : rd
   // polls a status bit; the count bounds the wait
   task automatic waitbit(input bit dev, input int b);
      int n;
      n = 0;
      do
      begin
         apb(dev, 1'b0, `REG_STATUS, 32'h0000_0000);
         n++;
      end
      while (rdat[b] !== 1'b1 && n < 60);
      check({31'h0, rdat[b]}, 32'h0000_0001);
   endtask : waitbit
   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_reset();
      check({28'h0, lnk.hostChipSelectN, lnk.portReadyAckN, lnk.timerOutputN,
             lnk.hostBusRequestN}, 32'h0000_000F);
      rd(1'b0, `REG_STATUS, 32'h0000_001F, 32'h0);
      rd(1'b1, `REG_CTRL, 32'hFFFF_FFFF, 32'h0);
      apb(1'b0, 1'b0, 8'h40, 32'h0000_0000);
      check({rdat[30:0], rerr}, 32'h0000_0001);
      apb(1'b1, 1'b0, 8'h40, 32'h0000_0000);
      check({rdat[30:0], rerr}, 32'h0000_0001);
      apb(1'b1, 1'b1, 8'h40, 32'hFFFF_FFFF);
      check({31'h0, rerr}, 32'h0000_0001);
      rd(1'b0, `REG_STATUS, 32'h0000_3800,
         {18'h0, `HOST_STRAPS, 11'h0});
   endtask : t_reset
   task automatic t_write(input bit csel, input logic [31:0] d);
      wr(1'b0, `REG_WDATA, d);
      wr(1'b0, `REG_CTRL, {24'h0, 4'hF, 1'b0, csel, 2'b11});
      waitbit(1'b0, `ST_DONE);
      wr(1'b0, `REG_STATUS, 32'h0000_0001);
      waitbit(1'b1, `ST_HOSTWR);
      rd(1'b1, csel ? `REG_PORTCTRL : `REG_PORTDATA, 32'hFFFF_FFFF, d);
      wr(1'b1, `REG_STATUS, 32'h0000_0002);
      rd(1'b1, `REG_STATUS, 32'h0000_0006, 32'h0);
   endtask : t_write
   task automatic t_read(input logic [31:0] d);
      wr(1'b1, `REG_PORTDATA, d);
      wr(1'b0, `REG_CTRL, 32'h0000_00F1);
      waitbit(1'b0, `ST_DONE);
      rd(1'b0, `REG_RDATA, 32'hFFFF_FFFF, d);
      waitbit(1'b1, `ST_HOSTRD);
      wr(1'b0, `REG_STATUS, 32'h0000_0001);
      wr(1'b1, `REG_STATUS, 32'h0000_0004);
   endtask : t_read
   task automatic t_irq();
      wr(1'b0, `REG_MASK, 32'h0000_0008);
      wr(1'b1, `REG_CTRL, 32'h0000_0100);
      waitbit(1'b1, `ST_IRQACK);
      check({31'h0, irqD}, 32'h0);
      check({31'h0, irqH}, 32'h1);
      rd(1'b1, `REG_CTRL, 32'h0000_0100, 32'h0);
      check({31'h0, lnk.timerOutputN}, 32'h1);
      wr(1'b1, `REG_MASK, 32'h0000_0008);
      @(posedge clk);
      check({31'h0, irqD}, 32'h1);
      wr(1'b1, `REG_STATUS, 32'h0000_0008);
      wr(1'b0, `REG_STATUS, 32'h0000_0008);
      check({30'h0, irqH, irqD}, 32'h0);
   endtask : t_irq
   // a frozen host must not acknowledge, so the request stays low
   task automatic t_freeze();
      wr(1'b1, `REG_CTRL, 32'h0000_0100);
      clkEn <= 1'b0;
      repeat (4) @(posedge clk);
      check({30'h0, lnk.timerOutputN, lnk.irqAckCycle}, 32'h0);
      clkEn <= 1'b1;
      waitbit(1'b1, `ST_IRQACK);
      wr(1'b1, `REG_STATUS, 32'h0000_0008);
      wr(1'b0, `REG_STATUS, 32'h0000_0008);
   endtask : t_freeze
   task automatic t_hold();
      wr(1'b1, `REG_CTRL, 32'h0000_0200);
      waitbit(1'b1, `ST_GRANT);
      rd(1'b1, `REG_STATUS, 32'h0000_0200, 32'h0000_0200);
      waitbit(1'b0, `ST_GRANT);
      wr(1'b1, `REG_CTRL, 32'h0);
      @(posedge clk);
      check({31'h0, lnk.hostBusRequestN}, 32'h1);
      wr(1'b1, `REG_STATUS, 32'h0000_0010);
      rd(1'b1, `REG_STATUS, 32'h0000_0010, 32'h0);
   endtask : t_hold
   // ***********************************
   // clock, watchdog and main sequence
   // ***********************************
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // about 20000 cycles; the full run needs a few hundred
   initial
   begin
      #1000000;
      failures++;
      finish_test();
   end
   initial
   begin
      failures    = 0;
      checks_done = 0;
      rst_n   = 1'b0;
      clkEn   = 1'b1;
      pselH   = 1'b0;
      pselD   = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_write(1'b0, 32'h5AC3_96E1);
      t_write(1'b1, 32'h0000_00A5);
      t_read(32'hC3A5_5A3C);
      t_irq();
      t_freeze();
      t_hold();
      t_read(32'h0F0F_F0F0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      finish_test();
   end
endmodule : tb

// *** common/host_port_consts.svh ***
// constants shared by both ends of the asynchronous host port link
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
// apb register byte offsets (both ends use the same layout style)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_MASK        8'h08
`define REG_ADDR        8'h0C
`define REG_WDATA       8'h10
`define REG_RDATA       8'h14
`define REG_PORTCTRL    8'h18
`define REG_PORTDATA    8'h1C
// ctrl register fields
`define CTRL_GO         0
`define CTRL_WRITE      1
`define CTRL_CSEL       2
`define CTRL_BE_LO      4
`define CTRL_IRQ        8
`define CTRL_HOLDREQ    9
// status register fields (sticky, write one to clear)
`define ST_DONE         0
`define ST_HOSTWR       1
`define ST_HOSTRD       2
`define ST_IRQACK       3
`define ST_GRANT        4
`define ST_WIDTH        5
// live status bits placed above the sticky bits
`define LIVE_BUSY       8
`define LIVE_HOLDA      9
`define LIVE_IRQ        10
// host strap value and module base location
`define HOST_STRAPS     3'h4
`define HOST_HOST_MODULE_BASE       32'h0003FF00
`define HOST_ACKSEL     2'h3
`define DEV_ACK_DELAY   4'h2
`endif

// *** common/host_port_if.sv ***
// wires between the host and the dsp asynchronous host port
`timescale 1ns/10ps
interface host_port_if;
   logic        hostChipSelectN;
   logic        directionSelect;
   logic        controlSelect;
   logic [3:0]  byteLaneEnablesN;
   logic [31:0] hostDataOut;
   logic        hostDataOe;
   logic [31:0] devDataOut;
   logic        devDataOe;
   logic        portReadyAckN;
   logic        hostBusRequestN;
   logic        hostBusGrantN;
   logic        hostGrantAckN;
   logic        busHoldRequest;
   logic        busHoldAck;
   logic        timerOutputN;
   logic        irqAckCycle;
   logic        autovectorInputN;
   wire  [31:0] dataBus;
   assign dataBus = hostDataOe ? hostDataOut :
                    (devDataOe ? devDataOut : 32'h0000_0000);
   modport host (
      output hostChipSelectN, directionSelect, controlSelect,
      output byteLaneEnablesN, hostDataOut, hostDataOe,
      output hostBusGrantN, irqAckCycle, autovectorInputN,
      input  portReadyAckN, hostBusRequestN, hostGrantAckN,
      input  timerOutputN, dataBus
   );
   modport device (
      input  hostChipSelectN, directionSelect, controlSelect,
      input  byteLaneEnablesN, hostBusGrantN, irqAckCycle,
      input  autovectorInputN, dataBus,
      output devDataOut, devDataOe, portReadyAckN,
      output hostBusRequestN, hostGrantAckN, busHoldRequest,
      output busHoldAck, timerOutputN
   );
endinterface : host_port_if

// *** common/host_port_pkg.sv ***
// types shared by both ends of the host port link
package host_port_pkg;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_STRB = 2'b01,
      H_WAIT = 2'b10,
      H_DONE = 2'b11
   } host_state_e;
   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_ACT  = 2'b01,
      D_ACK  = 2'b10,
      D_END  = 2'b11
   } dev_state_e;
endpackage : host_port_pkg

// *** hdl/device_end.sv ***
// dsp side: asynchronous host port slave with hold and irq
`timescale 1ns/10ps
`include "host_port_consts.svh"
// Overview of operation
// - port runs async, internal arbiter off
// - request bus only for fifo access
// - host address bit two picks register
// - host read/write line sets direction
// - chip select doubles as strobe
// - ready drives host transfer acknowledge
// - host straps set to 100
// - host autovector pin tied low
// - glue bridges hold to request/grant
// - timer output pin raises interrupt
// - host irq level one to seven
// - hold level seven until acknowledged
// - autovector only ends acknowledge cycles
// - host acknowledge select set to 11
module device_end
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   // link
   host_port_if.device      link
);
   // ********************************************************
   // pin synchronisers
   // ********************************************************
   logic [6:0] syncA_q, syncB_q;
   logic [31:0] dataA_q, dataB_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncA_q <= 7'h37;
         syncB_q <= 7'h37;
         dataA_q <= 32'h0000_0000;
         dataB_q <= 32'h0000_0000;
      end
      else if (clkEn)
      begin
         syncA_q <= {link.irqAckCycle, link.hostBusGrantN,
                     link.byteLaneEnablesN[0], link.controlSelect,
                     link.directionSelect, link.hostChipSelectN, 1'b1};
         syncB_q <= syncA_q;
         dataA_q <= link.dataBus;
         dataB_q <= dataA_q;
      end
   end
   logic csN, rdSel, cSel, grantN, iackIn;
   assign csN = syncB_q[1];
   assign rdSel = syncB_q[2];
   assign cSel = syncB_q[3];
   assign grantN = syncB_q[5];
   assign iackIn = syncB_q[6];

   // ********************************************************
   // port engine and registers
   // ********************************************************
   dev_state_e st_q, st_d;
   logic [31:0] ctrl_q, ctrl_d, pctl_q, pctl_d, pdat_q, pdat_d;
   logic [31:0] out_q, out_d;
   logic [`ST_WIDTH-1:0] stat_q, stat_d, mask_q, mask_d;
   logic [3:0]  cnt_q, cnt_d;
   logic        rdyN_q, rdyN_d, oe_q, oe_d, timer_output_q, timer_output_d;
   logic        hold_q, hold_d, gack_q, gack_d;
   logic [31:0] prdata_d;
   logic        pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
   logic        acc;
   assign acc = psel && penable && !pready_q;
   logic        wrAcc;
   assign wrAcc = psel && penable && pwrite && pready_q;
   always_comb
   begin
      st_d = st_q;
      ctrl_d = ctrl_q;
      pctl_d = pctl_q;
      pdat_d = pdat_q;
      out_d = out_q;
      stat_d = stat_q;
      mask_d = mask_q;
      cnt_d = cnt_q;
      rdyN_d = rdyN_q;
      oe_d = oe_q;
      timer_output_d = timer_output_q;
      prdata_d = prdata;
      pready_d = acc;
      pslverr_d = 1'b0;
      // writes land on the edge that samples pready high
      if (wrAcc)
      begin
         case (paddr)
            `REG_CTRL:     ctrl_d = pwdata;
            `REG_STATUS:   stat_d = stat_q & ~pwdata[`ST_WIDTH-1:0];
            `REG_MASK:     mask_d = pwdata[`ST_WIDTH-1:0];
            `REG_PORTCTRL: pctl_d = pwdata;
            `REG_PORTDATA: pdat_d = pwdata;
            default:       pdat_d = pdat_q;
         endcase
      end
      if (acc && pwrite)
      begin
         case (paddr)
            `REG_CTRL, `REG_STATUS, `REG_MASK, `REG_PORTCTRL,
            `REG_PORTDATA:
               pslverr_d = 1'b0;
            default:
               pslverr_d = 1'b1;
         endcase
      end
      else if (acc)
      begin
         case (paddr)
            `REG_CTRL:     prdata_d = ctrl_q;
            `REG_STATUS:   prdata_d = {21'h0, !timer_output_q, hold_q,
                                       st_q != D_IDLE, 3'h0, stat_q};
            `REG_MASK:     prdata_d = {27'h0, mask_q};
            `REG_PORTCTRL: prdata_d = pctl_q;
            `REG_PORTDATA: prdata_d = pdat_q;
            default:
            begin
               prdata_d = 32'h0000_0000;
               pslverr_d = 1'b1;
            end
         endcase
      end
      case (st_q)
         D_IDLE:
            if (!csN)
            begin
               cnt_d = `DEV_ACK_DELAY;
               st_d = D_ACT;
            end
         D_ACT:
            if (cnt_q != 4'h0)
               cnt_d = cnt_q - 4'h1;
            else
            begin
               if (rdSel)
               begin
                  out_d = cSel ? pctl_q : pdat_q;
                  oe_d = 1'b1;
                  stat_d[`ST_HOSTRD] = 1'b1;
               end
               else
               begin
                  if (cSel)
                     pctl_d = dataB_q;
                  else
                     pdat_d = dataB_q;
                  stat_d[`ST_HOSTWR] = 1'b1;
               end
               st_d = D_ACK;
            end
         D_ACK:
         begin
            rdyN_d = 1'b0;
            if (csN)
               st_d = D_END;
         end
         D_END:
         begin
            rdyN_d = 1'b1;
            oe_d = 1'b0;
            st_d = D_IDLE;
         end
         default: st_d = D_IDLE;
      endcase
      if (ctrl_q[`CTRL_IRQ] && !(wrAcc && paddr == `REG_CTRL))
         timer_output_d = 1'b1;
      if (iackIn && timer_output_q)
      begin
         timer_output_d = 1'b0;
         ctrl_d[`CTRL_IRQ] = 1'b0;
         stat_d[`ST_IRQACK] = 1'b1;
      end
      hold_d = ctrl_q[`CTRL_HOLDREQ];
      gack_d = hold_q && !grantN;
      if (gack_d && !gack_q)
         stat_d[`ST_GRANT] = 1'b1;
      irq_d = |(stat_d & mask_d);
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= D_IDLE;
         ctrl_q <= 32'h0000_0000;
         pctl_q <= 32'h0000_0000;
         pdat_q <= 32'h0000_0000;
         out_q <= 32'h0000_0000;
         stat_q <= 5'h00;
         mask_q <= 5'h00;
         cnt_q <= 4'h0;
         rdyN_q <= 1'b1;
         oe_q <= 1'b0;
         timer_output_q <= 1'b0;
         hold_q <= 1'b0;
         gack_q <= 1'b0;
         prdata <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else if (clkEn)
      begin
         st_q <= st_d;
         ctrl_q <= ctrl_d;
         pctl_q <= pctl_d;
         pdat_q <= pdat_d;
         out_q <= out_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         cnt_q <= cnt_d;
         rdyN_q <= rdyN_d;
         oe_q <= oe_d;
         timer_output_q <= timer_output_d;
         hold_q <= hold_d;
         gack_q <= gack_d;
         prdata <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
      end
   end
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   // ********************************************************
   // pin drive
   // ********************************************************
   assign link.devDataOut = out_q;
   assign link.devDataOe = oe_q;
   assign link.portReadyAckN = rdyN_q;
   assign link.timerOutputN = !timer_output_q;
   assign link.busHoldRequest = hold_q;
   assign link.busHoldAck = gack_q;
   assign link.hostBusRequestN = !hold_q;
   assign link.hostGrantAckN = !gack_q;
endmodule : device_end

// *** hdl/host_end.sv ***
// host side: cpu access engine driving the port, apb control
`timescale 1ns/10ps
`include "host_port_consts.svh"
module host_end
   import host_port_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   // link
   host_port_if.host        link
);
   // ********************************************************
   // pin synchronisers
   // ********************************************************
   logic [2:0] syncA_q, syncB_q;
   logic [31:0] dataA_q, dataB_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncA_q <= 3'h7;
         syncB_q <= 3'h7;
         dataA_q <= 32'h0000_0000;
         dataB_q <= 32'h0000_0000;
      end
      else if (clkEn)
      begin
         syncA_q <= {link.timerOutputN, link.hostBusRequestN,
                     link.portReadyAckN};
         syncB_q <= syncA_q;
         dataA_q <= link.dataBus;
         dataB_q <= dataA_q;
      end
   end
   logic ackN, reqN, irqN;
   assign ackN = syncB_q[0];
   assign reqN = syncB_q[1];
   assign irqN = syncB_q[2];

   // ********************************************************
   // access engine and registers
   // ********************************************************
   host_state_e st_q, st_d;
   logic [31:0] ctrl_q, ctrl_d, rdata_q, rdata_d, wdata_q, wdata_d;
   logic [`ST_WIDTH-1:0] stat_q, stat_d, mask_q, mask_d;
   logic        grantN_q, grantN_d, iack_q, iack_d, irq_q, irq_d;
   logic        irqSeen_q, irqSeen_d;
   logic        csN_q, csN_d, hoe_q, hoe_d;
   logic [31:0] prdata_d;
   logic        pready_d, pready_q, pslverr_d, pslverr_q;
   logic        acc;
   assign acc = psel && penable && !pready_q;
   logic        wrAcc;
   assign wrAcc = psel && penable && pwrite && pready_q;
   always_comb
   begin
      st_d = st_q;
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      wdata_d = wdata_q;
      stat_d = stat_q;
      mask_d = mask_q;
      grantN_d = reqN;
      iack_d = 1'b0;
      irqSeen_d = irqSeen_q;
      prdata_d = prdata;
      pready_d = acc;
      pslverr_d = 1'b0;
      // writes land on the edge that samples pready high
      if (wrAcc)
      begin
         case (paddr)
            `REG_CTRL:   ctrl_d = pwdata;
            `REG_STATUS: stat_d = stat_q & ~pwdata[`ST_WIDTH-1:0];
            `REG_MASK:   mask_d = pwdata[`ST_WIDTH-1:0];
            `REG_WDATA:  wdata_d = pwdata;
            default:     wdata_d = wdata_q;
         endcase
      end
      // the error flag must already stand with pready
      if (acc && pwrite)
      begin
         case (paddr)
            `REG_CTRL, `REG_STATUS, `REG_MASK, `REG_WDATA:
               pslverr_d = 1'b0;
            default:
               pslverr_d = 1'b1;
         endcase
      end
      else if (acc)
      begin
         case (paddr)
            `REG_CTRL:   prdata_d = ctrl_q;
            `REG_STATUS: prdata_d = {18'h0, `HOST_STRAPS, !irqN, 1'b0,
                                     st_q != H_IDLE, 3'h0, stat_q};
            `REG_MASK:   prdata_d = {27'h0, mask_q};
            `REG_WDATA:  prdata_d = wdata_q;
            `REG_RDATA:  prdata_d = rdata_q;
            default:
            begin
               prdata_d = 32'h0000_0000;
               pslverr_d = 1'b1;
            end
         endcase
      end
      if (!reqN && grantN_q)
         stat_d[`ST_GRANT] = 1'b1;
      if (!irqN && !irqSeen_q)
      begin
         iack_d = 1'b1;
         irqSeen_d = 1'b1;
      end
      else if (irqN)
         irqSeen_d = 1'b0;
      if (iack_q)
         stat_d[`ST_IRQACK] = 1'b1;
      case (st_q)
         H_IDLE:
            if (ctrl_q[`CTRL_GO] && reqN)
            begin
               ctrl_d[`CTRL_GO] = 1'b0;
               st_d = H_STRB;
            end
         H_STRB: st_d = H_WAIT;
         H_WAIT:
            if (!ackN)
            begin
               rdata_d = dataB_q;
               st_d = H_DONE;
            end
         H_DONE:
            if (ackN)
            begin
               stat_d[`ST_DONE] = 1'b1;
               st_d = H_IDLE;
            end
         default: st_d = H_IDLE;
      endcase
      irq_d = |(stat_d & mask_d);
      // strobe and drive enable registered so the pins cannot glitch
      csN_d = !(st_d == H_STRB || st_d == H_WAIT);
      hoe_d = !csN_d && ctrl_d[`CTRL_WRITE];
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= H_IDLE;
         ctrl_q <= 32'h0000_0000;
         rdata_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         stat_q <= 5'h00;
         mask_q <= 5'h00;
         grantN_q <= 1'b1;
         iack_q <= 1'b0;
         irqSeen_q <= 1'b0;
         irq_q <= 1'b0;
         csN_q <= 1'b1;
         hoe_q <= 1'b0;
         prdata <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else if (clkEn)
      begin
         st_q <= st_d;
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
         wdata_q <= wdata_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         grantN_q <= grantN_d;
         iack_q <= iack_d;
         irqSeen_q <= irqSeen_d;
         irq_q <= irq_d;
         csN_q <= csN_d;
         hoe_q <= hoe_d;
         prdata <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   // ********************************************************
   // pin drive
   // ********************************************************
   // chip select strobe
   assign link.hostChipSelectN = csN_q;
   assign link.controlSelect = ctrl_q[`CTRL_CSEL];
   assign link.directionSelect = !ctrl_q[`CTRL_WRITE];
   assign link.byteLaneEnablesN = ~ctrl_q[`CTRL_BE_LO+3:`CTRL_BE_LO];
   assign link.hostDataOut = wdata_q;
   assign link.hostDataOe = hoe_q;
   assign link.hostBusGrantN = grantN_q;
   assign link.irqAckCycle = iack_q;
   assign link.autovectorInputN = 1'b0;
endmodule : host_end
